/* design/gtp_pkg.sv */
package gtp_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  ADDR_CONTROL  = 4'h0;
  localparam logic [3:0]  ADDR_COUNT_LO = 4'h1;
  localparam logic [3:0]  ADDR_COUNT_HI = 4'h2;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_MASK  = 16'ha07a;
  localparam int BIT_RUN       = 15;
  localparam int BIT_IDLE_HALT = 13;
  localparam int BIT_GATE      = 6;
  localparam int BIT_PS_HI     = 5;
  localparam int BIT_PS_LO     = 4;
  localparam int BIT_PAIRED    = 3;
  localparam int BIT_EXT_CLK   = 1;
  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  localparam logic [7:0] PS_LIMIT_1   = 8'h00;
  localparam logic [7:0] PS_LIMIT_8   = 8'h07;
  localparam logic [7:0] PS_LIMIT_64  = 8'h3f;
  localparam logic [7:0] PS_LIMIT_256 = 8'hff;
  localparam logic [1:0] PS_DIV_1     = 2'h0;
  localparam logic [1:0] PS_DIV_8     = 2'h1;
  localparam logic [1:0] PS_DIV_64    = 2'h2;
  localparam logic [1:0] PS_DIV_256   = 2'h3;
endpackage

/* design/gtp_timer_pair.sv */
module gtp_timer_pair (
  input  wire logic        i_clk,        // peripheral clock, 10 MHz
  input  wire logic        i_rst,        // async reset, active high
  input  wire logic [3:0]  i_addr,       // register address
  input  wire logic [15:0] i_wdata,      // write data
  input  wire logic        i_wr,         // write strobe
  input  wire logic        i_rd,         // read strobe
  input  wire logic        i_idle,       // device idle mode
  input  wire logic        i_ext_pin,    // ext_count_pin, asynchronous
  input  wire logic        i_gate,       // gate input, asynchronous
  output logic      [15:0] o_rdata,      // read data, cycle after read
  output logic      [31:0] o_count,      // counter, low and high halves
  output logic             o_tick        // counter advanced this cycle
);
  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [15:0] control;
  wire         wr_control = i_wr && (i_addr == gtp_pkg::ADDR_CONTROL);
  wire         wr_lo      = i_wr && (i_addr == gtp_pkg::ADDR_COUNT_LO);
  wire         wr_hi      = i_wr && (i_addr == gtp_pkg::ADDR_COUNT_HI);
  wire         run_bit    = control[gtp_pkg::BIT_RUN];
  wire         idle_halt  = control[gtp_pkg::BIT_IDLE_HALT];
  wire         gate_bit   = control[gtp_pkg::BIT_GATE];
  wire   [1:0] ps_sel     = control[gtp_pkg::BIT_PS_HI:gtp_pkg::BIT_PS_LO];
  wire         paired     = control[gtp_pkg::BIT_PAIRED];
  wire         ext_sel    = control[gtp_pkg::BIT_EXT_CLK];

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      control <= gtp_pkg::CONTROL_RESET;
    else if (wr_control)
      control <= i_wdata & gtp_pkg::CONTROL_MASK;
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] ext_sync;
  logic [2:0] gate_sync;
  logic       ext_level;
  logic       gate_level;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ext_sync   <= 3'h0;
      gate_sync  <= 3'h0;
      ext_level  <= 1'b0;
      gate_level <= 1'b0;
    end
    else
    begin
      ext_sync  <= {ext_sync[1:0], i_ext_pin};
      gate_sync <= {gate_sync[1:0], i_gate};
      if (ext_sync[1] == ext_sync[2])
        ext_level <= ext_sync[2];
      if (gate_sync[1] == gate_sync[2])
        gate_level <= gate_sync[2];
    end
  end

  wire ext_rise = (ext_sync[1] == ext_sync[2]) && ext_sync[2] && !ext_level;

  // ----------------------------------------------------------------
  // source selection and prescaler
  // ----------------------------------------------------------------
  function automatic logic [7:0] ps_limit(input logic [1:0] sel);
    case (sel)
      gtp_pkg::PS_DIV_8:   ps_limit = gtp_pkg::PS_LIMIT_8;
      gtp_pkg::PS_DIV_64:  ps_limit = gtp_pkg::PS_LIMIT_64;
      gtp_pkg::PS_DIV_256: ps_limit = gtp_pkg::PS_LIMIT_256;
      default:             ps_limit = gtp_pkg::PS_LIMIT_1;
    endcase
  endfunction

  wire       halted    = idle_halt && i_idle;
  wire       gated     = gate_bit && !ext_sel;
  wire       src_tick  = ext_sel ? ext_rise : 1'b1;
  wire       src_ok    = gated ? gate_level : 1'b1;
  wire       active    = run_bit && !halted;
  wire       src_event = active && src_tick && src_ok;
  wire [7:0] limit     = ps_limit(ps_sel);
  logic [7:0] ps_count;
  wire       ps_wrap   = src_event && (ps_count >= limit);
  wire [7:0] next_ps_count = !active ? 8'h00 : (ps_wrap ? 8'h00 :
                             (src_event ? ps_count + 8'h01 : ps_count));

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      ps_count <= 8'h00;
    else
      ps_count <= next_ps_count;
  end

  // ----------------------------------------------------------------
  // counter halves
  // ----------------------------------------------------------------
  logic [15:0] count_lo;
  logic [15:0] count_hi;
  wire         lo_carry = ps_wrap && (count_lo == 16'hffff);
  wire         hi_step  = paired && lo_carry;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      count_lo <= 16'h0000;
      count_hi <= 16'h0000;
      o_tick   <= 1'b0;
    end
    else
    begin
      o_tick <= ps_wrap;
      if (wr_lo)
        count_lo <= i_wdata;
      else if (ps_wrap)
        count_lo <= count_lo + 16'h0001;
      if (wr_hi)
        count_hi <= i_wdata;
      else if (hi_step)
        count_hi <= count_hi + 16'h0001;
    end
  end

  assign o_count = {count_hi, count_lo};

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  wire [15:0] rd_mux = (i_addr == gtp_pkg::ADDR_CONTROL)  ? control  :
                       (i_addr == gtp_pkg::ADDR_COUNT_LO) ? count_lo :
                       (i_addr == gtp_pkg::ADDR_COUNT_HI) ? count_hi : 16'h0000;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= 16'h0000;
    else
      o_rdata <= i_rd ? rd_mux : 16'h0000;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_stopped_no_count: assert property (@(posedge i_clk) disable iff (i_rst)
    !run_bit && !$past(run_bit) && !$past(wr_lo) |-> $stable(count_lo))
    else $error("counter moved while stopped");
  chk_idle_halt_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (idle_halt && i_idle) |-> !ps_wrap)
    else $error("timer advanced in idle with halt set");
  chk_idle_runs_on: assert property (@(posedge i_clk) disable iff (i_rst)
    (run_bit && !idle_halt && !ext_sel && !gate_bit && ps_sel == 2'h0) |-> ps_wrap)
    else $error("timer stalled in idle without halt");
  chk_gate_low_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (gate_bit && !ext_sel && !gate_level) |-> !ps_wrap)
    else $error("gated timer advanced with gate low");
  chk_gate_ignored_ext: assert property (@(posedge i_clk) disable iff (i_rst)
    (ext_sel && run_bit && !halted && ext_rise && ps_sel == 2'h0) |-> ps_wrap)
    else $error("external edge lost with gate bit set");
  chk_div8_spacing: assert property (@(posedge i_clk) disable iff (i_rst)
    (ps_wrap && ps_sel == 2'h1 && !ext_sel && !gate_bit && !i_idle) ##1
    (run_bit && ps_sel == 2'h1 && !ext_sel && !gate_bit && !i_idle) [*6] |-> !ps_wrap)
    else $error("divide by 8 ticked early");
  chk_pair_carry: assert property (@(posedge i_clk) disable iff (i_rst)
    (paired && lo_carry && !wr_hi) |=> (count_hi == $past(count_hi) + 16'h0001))
    else $error("paired carry lost");
  chk_split_no_carry: assert property (@(posedge i_clk) disable iff (i_rst)
    (!paired && !wr_hi) |=> $stable(count_hi))
    else $error("high half moved in split mode");
  chk_ext_edge_only: assert property (@(posedge i_clk) disable iff (i_rst)
    (ext_sel && !ext_rise) |-> !ps_wrap)
    else $error("external mode counted without edge");
  chk_reserved_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    (control & ~gtp_pkg::CONTROL_MASK) == 16'h0000)
    else $error("reserved control bit set");

  // ----------------------------------------------------------------
  // register bus checks
  // ----------------------------------------------------------------
  chk_rdata_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rd) |-> (o_rdata == 16'h0000))
    else $error("read data shown without a read");

  chk_rdata_control: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_rd) && ($past(i_addr) == gtp_pkg::ADDR_CONTROL) |-> (o_rdata == $past(control)))
    else $error("control read back wrong");

  chk_rdata_low: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_rd) && ($past(i_addr) == gtp_pkg::ADDR_COUNT_LO) |-> (o_rdata == $past(count_lo)))
    else $error("low half read back wrong");

  chk_rdata_high: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_rd) && ($past(i_addr) == gtp_pkg::ADDR_COUNT_HI) |-> (o_rdata == $past(count_hi)))
    else $error("high half read back wrong");

  chk_rdata_unmapped: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_rd) && ($past(i_addr) > gtp_pkg::ADDR_COUNT_HI) |-> (o_rdata == 16'h0000))
    else $error("unmapped address read nonzero");

  chk_control_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_control |=> (control == ($past(i_wdata) & gtp_pkg::CONTROL_MASK)))
    else $error("control write not masked");

  chk_control_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !wr_control |=> $stable(control))
    else $error("control changed without a write");

  chk_low_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_lo |=> (count_lo == $past(i_wdata)))
    else $error("low half write lost");

  chk_high_write: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_hi |=> (count_hi == $past(i_wdata)))
    else $error("high half write lost");

  // ----------------------------------------------------------------
  // prescaler and source checks
  // ----------------------------------------------------------------
  chk_ps_clear_stop: assert property (@(posedge i_clk) disable iff (i_rst)
    !active |=> (ps_count == 8'h00))
    else $error("prescaler kept count while inactive");

  chk_ps_step: assert property (@(posedge i_clk) disable iff (i_rst)
    src_event && !ps_wrap |=> (ps_count == $past(ps_count) + 8'h01))
    else $error("prescaler missed an event");

  chk_ps_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    active && !src_event |=> $stable(ps_count))
    else $error("prescaler moved without an event");

  chk_ps_wrap_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    ps_wrap |=> (ps_count == 8'h00))
    else $error("prescaler not cleared on wrap");

  chk_div1_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
    src_event && (ps_sel == gtp_pkg::PS_DIV_1) |-> ps_wrap)
    else $error("undivided event did not tick");

  chk_halt_no_event: assert property (@(posedge i_clk) disable iff (i_rst)
    halted |-> !src_event)
    else $error("event accepted while halted");

  chk_stopped_no_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
    !run_bit |-> !ps_wrap)
    else $error("tick while run bit clear");

  chk_internal_every: assert property (@(posedge i_clk) disable iff (i_rst)
    active && !ext_sel && !gate_bit |-> src_event)
    else $error("internal clock event lost");

  chk_gate_high_runs: assert property (@(posedge i_clk) disable iff (i_rst)
    active && gated && gate_level |-> src_event)
    else $error("gated event lost with gate high");

  chk_gate_ignored_src: assert property (@(posedge i_clk) disable iff (i_rst)
    ext_sel |-> src_ok)
    else $error("gate applied to external source");

  chk_ext_no_edge: assert property (@(posedge i_clk) disable iff (i_rst)
    ext_sel && !ext_rise |-> !src_event)
    else $error("external event without an edge");

  chk_ext_rise_pulse: assert property (@(posedge i_clk) disable iff (i_rst)
    ext_rise |=> !ext_rise)
    else $error("external edge seen twice");

  chk_ext_filter: assert property (@(posedge i_clk) disable iff (i_rst)
    (ext_sync[1] != ext_sync[2]) |=> $stable(ext_level))
    else $error("external level moved on disagreement");

  chk_gate_filter: assert property (@(posedge i_clk) disable iff (i_rst)
    (gate_sync[1] != gate_sync[2]) |=> $stable(gate_level))
    else $error("gate level moved on disagreement");

  // ----------------------------------------------------------------
  // counter checks
  // ----------------------------------------------------------------
  chk_low_step: assert property (@(posedge i_clk) disable iff (i_rst)
    ps_wrap && !wr_lo |=> (count_lo == $past(count_lo) + 16'h0001))
    else $error("low half missed a tick");

  chk_low_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !ps_wrap && !wr_lo |=> $stable(count_lo))
    else $error("low half moved without a tick");

  chk_low_wraps: assert property (@(posedge i_clk) disable iff (i_rst)
    lo_carry && !wr_lo |=> (count_lo == 16'h0000))
    else $error("low half did not wrap");

  chk_split_no_step: assert property (@(posedge i_clk) disable iff (i_rst)
    !paired |-> !hi_step)
    else $error("carry taken in split mode");

  chk_pair_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    paired && !hi_step && !wr_hi |=> $stable(count_hi))
    else $error("high half moved without carry");

  chk_tick_follows: assert property (@(posedge i_clk) disable iff (i_rst)
    ps_wrap |=> o_tick)
    else $error("tick output missing");

  chk_tick_only: assert property (@(posedge i_clk) disable iff (i_rst)
    !ps_wrap |=> !o_tick)
    else $error("tick output without advance");
endmodule

/* dv/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // stimulus and design
  // ----------------------------------------------------------------
  logic        i_clk     = 1'b0;
  logic        i_rst     = 1'b1;
  logic [3:0]  i_addr    = 4'h0;
  logic [15:0] i_wdata   = 16'h0000;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic        i_idle    = 1'b0;
  logic        i_ext_pin = 1'b0;
  logic        i_gate    = 1'b0;
  logic [15:0] o_rdata;
  logic [31:0] o_count;
  logic        o_tick;
  int          miscompares = 0;
  int          num_checks  = 0;
  logic [15:0] rv;
  logic [31:0] base;
  int          k;
  int          divs [4] = '{1, 8, 64, 256};
  always #50 i_clk = ~i_clk;
  gtp_timer_pair gtp_timer_pair_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_idle(i_idle), .i_ext_pin(i_ext_pin), .i_gate(i_gate),
    .o_rdata(o_rdata), .o_count(o_count), .o_tick(o_tick));
  // ----------------------------------------------------------------
  // bus, compare and closing tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", name, e, g);
      miscompares++;
    end
  endtask
  // counts ticks seen over n cycles
  task automatic ticks(input int n, output int c);
    c = 0;
    repeat (n)
    begin
      @(negedge i_clk);
      if (o_tick === 1'b1) c++;
    end
  endtask
  // cycles between two consecutive ticks, bounded
  task automatic gap(output int c);
    int w;
    w = 0;
    c = 0;
    @(negedge i_clk);
    while (o_tick !== 1'b1 && w < 600)
    begin
      @(negedge i_clk);
      w++;
    end
    do
    begin
      @(negedge i_clk);
      c++;
    end while (o_tick !== 1'b1 && c < 600);
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(4'h0, rv); chk("control reset", 32'h0, {16'h0, rv});
    wr(4'h0, 16'hffff); rd(4'h0, rv); chk("control mask", 32'ha07a, {16'h0, rv});
    wr(4'h0, 16'h0000); rd(4'h7, rv); chk("unmapped", 32'h0, {16'h0, rv});
  endtask
  task automatic t_prescale();
    for (int c = 0; c < 4; c++)
    begin
      wr(4'h1, 16'h0000);
      wr(4'h0, 16'h8000 | 16'(c << 4));
      gap(k); chk("tick gap", 32'(divs[c]), 32'(k));
      wr(4'h0, 16'h0000);
      @(negedge i_clk);
      ticks(20, k); chk("stopped ticks", 32'h0, 32'(k));
    end
  endtask
  task automatic t_idle();
    @(posedge i_clk) i_idle <= 1'b1;
    wr(4'h0, 16'ha000); ticks(20, k); chk("idle halted", 32'h0, 32'(k));
    wr(4'h0, 16'h8000); repeat (4) @(negedge i_clk);
    ticks(20, k); chk("idle running", 32'd20, 32'(k));
    wr(4'h0, 16'h0000);
    @(posedge i_clk) i_idle <= 1'b0;
  endtask
  task automatic t_gate();
    wr(4'h0, 16'h8050); ticks(40, k); chk("gate low", 32'h0, 32'(k));
    @(posedge i_clk) i_gate <= 1'b1;
    repeat (10) @(negedge i_clk);
    gap(k); chk("gated gap", 32'd8, 32'(k));
    @(posedge i_clk) i_gate <= 1'b0;
    wr(4'h0, 16'h8000); repeat (4) @(negedge i_clk);
    ticks(20, k); chk("ungated", 32'd20, 32'(k));
    // external source with gating asked for: gate bit must be ignored
    wr(4'h0, 16'h8042); repeat (8) @(negedge i_clk);
    base = o_count;
    repeat (5)
    begin
      repeat (5) @(posedge i_clk) i_ext_pin <= 1'b1;
      repeat (5) @(posedge i_clk) i_ext_pin <= 1'b0;
    end
    repeat (10) @(negedge i_clk);
    chk("ext edges", base + 32'd5, o_count);
    wr(4'h0, 16'h0000);
  endtask
  task automatic t_pair(input logic [15:0] ctl, input logic [15:0] hi);
    wr(4'h1, 16'hffff); wr(4'h2, 16'h0000); wr(4'h0, ctl);
    repeat (6) @(negedge i_clk);
    wr(4'h0, 16'h0000); @(negedge i_clk);
    chk("high half", {16'h0, hi}, {16'h0, o_count[31:16]});
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    t_prescale();
    t_idle();
    t_gate();
    t_pair(16'h8008, 16'h0001);
    t_pair(16'h8000, 16'h0000);
    conclude();
  end
  initial
  begin
    #(100 * 20000);
    miscompares++;
    conclude();
  end
endmodule
